// file: rtl/dagm_top.v
// Function
// - mac prefetch pointers only W8..W11; W8/W9 to X read, W10/W11 to Y
// - mac register-offset indexing only through W9 (X) and W11 (Y)
// - mac modes: indirect, post-modify by 2, 4 or 6, register offset
// - move source and destination modes differ; one shared 4-bit offset field
// - move modes: direct, indirect, pre/post modify, offsets, 8/16-bit literals
// - branch takes 16-bit signed literal; hold instruction a 14-bit literal
// - one circular buffer in X space and one in Y space
// - buffer bounds from 16-bit start and end registers, up to 32K words
// - Y circular addresses are word sized, effective address bit 0 cleared
// - X pointer select in control 3:0; value 15 disables X modulo
// - X circular active when select is not 15 and bit 15 set
// - Y select in control 7:4; active when not 15 and bit 14 set
// - bounds compared greater-than end and less-than start, not equality
// - pre/post modify writes corrected pointer back; offsets leave it alone
// - buffers run one way; power-of-two buffers check both boundaries
// - bit-reversed addressing only in X write generator, data writes only
// - bit-reversed mode reverses pointer and modifier, adds, reverses the sum back
// - bit-reverse active: select not 15, enable set, pre/post increment
// - with both enabled, bit-reverse wins in X write; X read keeps modulo
//
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "dagm_defines.vh"

module dagm_top (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // register bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // request from the instruction decoder
  input wire req_valid,
  input wire [1:0] req_class,
  input wire byte_op,
  input wire [2:0] src_mode,
  input wire [3:0] src_reg,
  input wire [2:0] dst_mode,
  input wire [3:0] dst_reg,
  input wire [3:0] offset_register_field,
  input wire [1:0] lit_sel,
  input wire [15:0] literal,
  input wire [1:0] mac_x_mode,
  input wire mac_x_reg,
  input wire [1:0] mac_x_amt,
  input wire mac_x_dec,
  input wire [1:0] mac_y_mode,
  input wire mac_y_reg,
  input wire [1:0] mac_y_amt,
  input wire mac_y_dec,
  // working register file contents, W0 in the low bits
  input wire [255:0] w_file,
  // addresses toward data memory
  output reg out_valid,
  output reg x_rd_en,
  output reg [15:0] x_rd_addr,
  output reg x_wr_en,
  output reg [15:0] x_wr_addr,
  output reg y_en,
  output reg [15:0] y_addr,
  // pointer write-back toward the register file
  output reg wb0_en,
  output reg [3:0] wb0_idx,
  output reg [15:0] wb0_data,
  output reg wb1_en,
  output reg [3:0] wb1_idx,
  output reg [15:0] wb1_data,
  // literal operands and faults
  output reg [15:0] operand_literal,
  output reg [15:0] branch_disp,
  output reg [13:0] hold_count,
  output reg addr_fault
);

  reg [15:0] ctrl_reg;
  reg [15:0] xsrt_reg;
  reg [15:0] xend_reg;
  reg [15:0] ysrt_reg;
  reg [15:0] yend_reg;
  reg [15:0] brev_reg;
  reg [7:0] dp_addr_reg;
  reg dp_write_reg;
  reg [15:0] ctrl_next;
  reg [15:0] xsrt_next;
  reg [15:0] xend_next;
  reg [15:0] ysrt_next;
  reg [15:0] yend_next;
  reg [15:0] brev_next;
  reg [31:0] rdata_next;
  wire addr_phase;

  wire [3:0] x_sel;
  wire [3:0] y_sel;
  wire [3:0] b_sel;
  wire xm_on;
  wire ym_on;
  wire br_on;

  reg [2:0] xr_md;
  reg [3:0] xr_idx;
  reg [15:0] xr_d;
  reg [2:0] xw_md;
  reg [3:0] xw_idx;
  reg [15:0] xw_d;
  reg [2:0] y_md;
  reg [3:0] y_idx;
  reg [15:0] y_d;
  reg fault_c;
  reg [15:0] lit_c;
  wire [15:0] step;
  wire [15:0] ofs_val;
  wire [15:0] xr_p;
  wire [15:0] xw_p;
  wire [15:0] y_p;
  wire xw_br;
  wire [15:0] rev_p;
  wire [15:0] rev_m;
  wire [15:0] brev_sh;
  wire [15:0] rev_sum;
  wire [15:0] br_mv;
  wire [15:0] xw_mv;
  wire [33:0] xr_o;
  wire [33:0] xw_o;
  wire [33:0] y_o;

  // address phase of a transfer aimed at this slave
  assign addr_phase = hsel & htrans[1] & hready;

  // bus address and direction held into the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_addr_reg <= 8'h00;
      dp_write_reg <= 1'b0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      dp_addr_reg <= haddr[7:0];
      dp_write_reg <= addr_phase & hwrite;
      hreadyout <= 1'b1; // zero wait states, always OKAY
      hresp <= 1'b0;
    end
  end

  // register writes land in the data phase; unmapped offsets ignored
  always @*
  begin
    ctrl_next = ctrl_reg;
    xsrt_next = xsrt_reg;
    xend_next = xend_reg;
    ysrt_next = ysrt_reg;
    yend_next = yend_reg;
    brev_next = brev_reg;
    if (dp_write_reg)
    begin
      case (dp_addr_reg)
        `DAGM_OFS_CTRL: ctrl_next = hwdata[15:0] & `DAGM_CTRL_MASK;
        `DAGM_OFS_XSRT: xsrt_next = hwdata[15:0];
        `DAGM_OFS_XEND: xend_next = hwdata[15:0];
        `DAGM_OFS_YSRT: ysrt_next = hwdata[15:0];
        `DAGM_OFS_YEND: yend_next = hwdata[15:0];
        `DAGM_OFS_BREV: brev_next = hwdata[15:0];
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  // read mux works on next values so a read right after a write is fresh
  always @*
  begin
    case (haddr[7:0])
      `DAGM_OFS_CTRL: rdata_next = {16'h0000, ctrl_next};
      `DAGM_OFS_XSRT: rdata_next = {16'h0000, xsrt_next};
      `DAGM_OFS_XEND: rdata_next = {16'h0000, xend_next};
      `DAGM_OFS_YSRT: rdata_next = {16'h0000, ysrt_next};
      `DAGM_OFS_YEND: rdata_next = {16'h0000, yend_next};
      `DAGM_OFS_BREV: rdata_next = {16'h0000, brev_next};
      `DAGM_OFS_STAT: rdata_next = {x_wr_addr, x_rd_addr};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // register file and read data
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= `DAGM_CTRL_RST;
      xsrt_reg <= `DAGM_ADDR_RST;
      xend_reg <= `DAGM_ADDR_RST;
      ysrt_reg <= `DAGM_ADDR_RST;
      yend_reg <= `DAGM_ADDR_RST;
      brev_reg <= `DAGM_BREV_RST;
      hrdata <= 32'h00000000;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      xsrt_reg <= xsrt_next;
      xend_reg <= xend_next;
      ysrt_reg <= ysrt_next;
      yend_reg <= yend_next;
      brev_reg <= brev_next;
      if (addr_phase & ~hwrite)
        hrdata <= rdata_next;
    end
  end

  // feature enables from the control register, bit-reverse enable from brev_reg
  assign x_sel = ctrl_reg[`DAGM_XSEL_LSB+3:`DAGM_XSEL_LSB];
  assign y_sel = ctrl_reg[`DAGM_YSEL_LSB+3:`DAGM_YSEL_LSB];
  assign b_sel = ctrl_reg[`DAGM_BSEL_LSB+3:`DAGM_BSEL_LSB];
  assign xm_on = (x_sel != `DAGM_SEL_OFF) & ctrl_reg[`DAGM_XMEN_BIT];
  assign ym_on = (y_sel != `DAGM_SEL_OFF) & ctrl_reg[`DAGM_YMEN_BIT];
  assign br_on = (b_sel != `DAGM_SEL_OFF) & brev_reg[`DAGM_BITREV_ENABLE_BIT];

  // byte ops step by one, word ops by two
  assign step = byte_op ? 16'h0001 : 16'h0002;
  assign ofs_val = w_file[offset_register_field*16 +: 16];

  // step or offset for a generic mode
  function [15:0] mod_amt;
    input [2:0] md;
    input [15:0] st;
    input [15:0] ofs;
    input [15:0] lit;
    begin
      case (md)
        `DAGM_MD_POSTI, `DAGM_MD_PREI: mod_amt = st;
        `DAGM_MD_POSTD, `DAGM_MD_PRED: mod_amt = 16'h0000 - st;
        `DAGM_MD_ROFS: mod_amt = ofs;
        `DAGM_MD_LOFS: mod_amt = lit;
        default: mod_amt = 16'h0000;
      endcase
    end
  endfunction

  // mac post-modify amount of 2, 4 or 6, signed by direction
  function [15:0] mac_amt;
    input [1:0] amt;
    input dec;
    reg [15:0] mag;
    begin
      mag = {13'h0000, amt, 1'b0};
      mac_amt = dec ? 16'h0000 - mag : mag;
    end
  endfunction

  // select the three generators' work from the instruction class
  always @*
  begin
    xr_md = `DAGM_MD_DIR;
    xr_idx = 4'h0;
    xr_d = 16'h0000;
    xw_md = `DAGM_MD_DIR;
    xw_idx = 4'h0;
    xw_d = 16'h0000;
    y_md = `DAGM_MD_DIR;
    y_idx = 4'h0;
    y_d = 16'h0000;
    fault_c = 1'b0;
    lit_c = 16'h0000;
    case (req_class)
      `DAGM_CL_MOVE:
      begin
        // source on the X read side, destination on the X write side
        xr_md = src_mode;
        xr_idx = src_reg;
        xr_d = mod_amt(src_mode, step, ofs_val, literal);
        xw_md = dst_mode;
        xw_idx = dst_reg;
        xw_d = mod_amt(dst_mode, step, ofs_val, literal);
        if (lit_sel == `DAGM_LIT_8)
          lit_c = {8'h00, literal[7:0]};
        else if (lit_sel == `DAGM_LIT_16)
          lit_c = literal;
        else
          fault_c = (lit_sel != `DAGM_LIT_NONE);
      end
      `DAGM_CL_MAC:
      begin
        // W8/W9 to X read, W10/W11 to Y
        xr_idx = {3'h4, mac_x_reg};
        y_idx = {3'h5, mac_y_reg};
        case (mac_x_mode)
          `DAGM_MAC_IND: xr_md = `DAGM_MD_IND;
          `DAGM_MAC_POST:
          begin
            xr_md = mac_x_dec ? `DAGM_MD_POSTD : `DAGM_MD_POSTI;
            xr_d = mac_amt(mac_x_amt, mac_x_dec);
            fault_c = (mac_x_amt == 2'h0);
          end
          `DAGM_MAC_IDX:
          begin
            // indexing only through W9; W8 falls back to plain indirect
            xr_md = mac_x_reg ? `DAGM_MD_ROFS : `DAGM_MD_IND;
            xr_d = ofs_val;
            fault_c = ~mac_x_reg;
          end
          default: xr_md = `DAGM_MD_DIR;
        endcase
        case (mac_y_mode)
          `DAGM_MAC_IND: y_md = `DAGM_MD_IND;
          `DAGM_MAC_POST:
          begin
            y_md = mac_y_dec ? `DAGM_MD_POSTD : `DAGM_MD_POSTI;
            y_d = mac_amt(mac_y_amt, mac_y_dec);
            if (mac_y_amt == 2'h0)
              fault_c = 1'b1;
          end
          `DAGM_MAC_IDX:
          begin
            y_md = mac_y_reg ? `DAGM_MD_ROFS : `DAGM_MD_IND;
            y_d = ofs_val;
            if (!mac_y_reg)
              fault_c = 1'b1;
          end
          default: y_md = `DAGM_MD_DIR;
        endcase
      end
      `DAGM_CL_BRA: lit_c = literal;
      `DAGM_CL_HOLD: lit_c = {2'h0, literal[13:0]};
      default: lit_c = 16'h0000;
    endcase
  end

  assign xr_p = w_file[xr_idx*16 +: 16];
  assign xw_p = w_file[xw_idx*16 +: 16];
  assign y_p = w_file[y_idx*16 +: 16];

  // bit-reverse only on word writes with pre/post increment
  assign xw_br = br_on & (xw_idx == b_sel) & ~byte_op
    & (req_class == `DAGM_CL_MOVE)
    & ((xw_md == `DAGM_MD_POSTI) | (xw_md == `DAGM_MD_PREI));

  // modifier counts words; one left shift makes it a byte step, enable drops
  assign brev_sh = {brev_reg[14:0], 1'b0};
  // reverse-carry add: pointer and modifier both reversed, summed, result reversed back
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_rev
      assign rev_p[gi] = xw_p[15-gi];
      assign rev_m[gi] = brev_sh[15-gi];
      assign br_mv[gi] = (gi == 0) ? 1'b0 : rev_sum[15-gi];
    end
  endgenerate
  // modifier scaled to bytes: word index bit k sits at byte bit k+1
  assign rev_sum = rev_p + rev_m;
  assign xw_mv = xw_br ? br_mv : xw_p + xw_d;

  // one generator: {acc, wb, ea, new pointer}
  function [33:0] agu;
    input [2:0] md;
    input [15:0] p;
    input [15:0] mv;
    input [15:0] d;
    input men;
    input [15:0] s;
    input [15:0] e;
    input yw;
    reg [16:0] len;
    reg pow2;
    reg hi;
    reg lo;
    reg [15:0] c;
    reg [15:0] ea;
    begin
      len = {1'b0, e} - {1'b0, s} + 17'h00001;
      pow2 = ((len & (len - 17'h00001)) == 17'h00000);
      hi = men & (~d[15] | pow2) & (mv > e);
      lo = men & (d[15] | pow2) & (mv < s);
      if (hi)
        c = s + (mv - e - 16'h0001);
      else if (lo)
        c = e - (s - mv - 16'h0001);
      else
        c = mv;
      if (yw)
        c = {c[15:1], 1'b0};
      case (md)
        `DAGM_MD_PREI, `DAGM_MD_PRED, `DAGM_MD_ROFS, `DAGM_MD_LOFS:
          ea = c;
        default: ea = yw ? {p[15:1], 1'b0} : p;
      endcase
      agu[33] = (md != `DAGM_MD_DIR);
      agu[32] = (md >= `DAGM_MD_POSTI) & (md <= `DAGM_MD_PRED);
      agu[31:16] = ea;
      agu[15:0] = c;
    end
  endfunction

  // X read keeps modulo even while bit-reverse owns the X write side
  assign xr_o = agu(xr_md, xr_p, xr_p + xr_d, xr_d,
    xm_on & (xr_idx == x_sel), xsrt_reg, xend_reg, 1'b0);
  assign xw_o = agu(xw_md, xw_p, xw_mv, xw_d,
    xm_on & ~br_on & (xw_idx == x_sel), xsrt_reg, xend_reg, 1'b0);
  assign y_o = agu(y_md, y_p, y_p + y_d, y_d,
    ym_on & (y_idx == y_sel), ysrt_reg, yend_reg, 1'b1);

  // registered addresses, write-backs and literals
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_valid <= 1'b0;
      x_rd_en <= 1'b0;
      x_rd_addr <= 16'h0000;
      x_wr_en <= 1'b0;
      x_wr_addr <= 16'h0000;
      y_en <= 1'b0;
      y_addr <= 16'h0000;
      wb0_en <= 1'b0;
      wb0_idx <= 4'h0;
      wb0_data <= 16'h0000;
      wb1_en <= 1'b0;
      wb1_idx <= 4'h0;
      wb1_data <= 16'h0000;
      operand_literal <= 16'h0000;
      branch_disp <= 16'h0000;
      hold_count <= 14'h0000;
      addr_fault <= 1'b0;
    end
    else
    begin
      out_valid <= req_valid;
      x_rd_en <= req_valid & xr_o[33];
      x_wr_en <= req_valid & xw_o[33];
      y_en <= req_valid & y_o[33];
      addr_fault <= req_valid & fault_c;
      wb0_en <= req_valid & xr_o[32];
      wb1_en <= req_valid & (xw_o[32] | y_o[32]);
      if (req_valid)
      begin
        x_rd_addr <= xr_o[31:16];
        x_wr_addr <= xw_o[31:16];
        y_addr <= y_o[31:16];
        wb0_idx <= xr_idx;
        wb0_data <= xr_o[15:0];
        // the Y pointer only moves in mac, the X write only in move
        wb1_idx <= (req_class == `DAGM_CL_MAC) ? y_idx : xw_idx;
        wb1_data <= (req_class == `DAGM_CL_MAC) ? y_o[15:0] : xw_o[15:0];
        operand_literal <= lit_c;
        if (req_class == `DAGM_CL_BRA)
          branch_disp <= lit_c;
        if (req_class == `DAGM_CL_HOLD)
          hold_count <= lit_c[13:0];
      end
    end
  end

endmodule // dagm_top

// file: rtl/dagm_defines.vh
`ifndef DAGM_DEFINES_VH
`define DAGM_DEFINES_VH

// register byte offsets on the bus
`define DAGM_OFS_CTRL 8'h00
`define DAGM_OFS_XSRT 8'h04
`define DAGM_OFS_XEND 8'h08
`define DAGM_OFS_YSRT 8'h0C
`define DAGM_OFS_YEND 8'h10
`define DAGM_OFS_BREV 8'h14
`define DAGM_OFS_STAT 8'h18

// control register fields; the bit-reverse enable bit lies in brev_reg
`define DAGM_XSEL_LSB 0
`define DAGM_YSEL_LSB 4
`define DAGM_BSEL_LSB 8
`define DAGM_YMEN_BIT 14
`define DAGM_XMEN_BIT 15
`define DAGM_CTRL_MASK 16'hCFFF
`define DAGM_BITREV_ENABLE_BIT 15

// reset values
`define DAGM_CTRL_RST 16'h0000
`define DAGM_ADDR_RST 16'h0000
`define DAGM_BREV_RST 16'h0000

// pointer select value that switches a feature off
`define DAGM_SEL_OFF 4'hF

// instruction classes
`define DAGM_CL_MOVE 2'h0
`define DAGM_CL_MAC 2'h1
`define DAGM_CL_BRA 2'h2
`define DAGM_CL_HOLD 2'h3

// generic addressing modes
`define DAGM_MD_DIR 3'h0
`define DAGM_MD_IND 3'h1
`define DAGM_MD_POSTI 3'h2
`define DAGM_MD_POSTD 3'h3
`define DAGM_MD_PREI 3'h4
`define DAGM_MD_PRED 3'h5
`define DAGM_MD_ROFS 3'h6
`define DAGM_MD_LOFS 3'h7

// multiply-accumulate operand modes
`define DAGM_MAC_IND 2'h0
`define DAGM_MAC_POST 2'h1
`define DAGM_MAC_IDX 2'h2
`define DAGM_MAC_NONE 2'h3

// literal operand selection
`define DAGM_LIT_NONE 2'h0
`define DAGM_LIT_8 2'h1
`define DAGM_LIT_16 2'h2

`endif

// file: test/dagm_rf_model.sv
`timescale 1ns/1ps

module dagm_rf_model (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // preload from the bench
  input wire set_en,
  input wire [3:0] set_idx,
  input wire [15:0] set_data,
  // pointer write-back from the block
  input wire wb0_en,
  input wire [3:0] wb0_idx,
  input wire [15:0] wb0_data,
  input wire wb1_en,
  input wire [3:0] wb1_idx,
  input wire [15:0] wb1_data,
  // register contents toward the block
  output wire [255:0] w_file
);
  logic [255:0] w_reg;

  // write-back lands one edge after the answer, before a dependent request
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      w_reg <= 256'h0;
    else if (set_en)
      w_reg[set_idx*16 +: 16] <= set_data;
    else
    begin
      if (wb1_en)
        w_reg[wb1_idx*16 +: 16] <= wb1_data;
      // read pointer last, so it wins a same-register clash
      if (wb0_en)
        w_reg[wb0_idx*16 +: 16] <= wb0_data;
    end

  assign w_file = w_reg;
endmodule // dagm_rf_model

// file: test/dagm_top_chk.sv
`timescale 1ns/1ps
`include "dagm_defines.vh"

module dagm_top_chk (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus answer
  input wire hreadyout,
  input wire hresp,
  // request
  input wire req_valid,
  input wire [1:0] req_class,
  input wire [1:0] lit_sel,
  input wire [15:0] literal,
  input wire [1:0] mac_x_mode,
  input wire mac_x_reg,
  input wire [1:0] mac_x_amt,
  input wire [1:0] mac_y_mode,
  input wire [255:0] w_file,
  // results
  input wire out_valid,
  input wire x_rd_en,
  input wire [15:0] x_rd_addr,
  input wire x_wr_en,
  input wire y_en,
  input wire [15:0] branch_disp,
  input wire [13:0] hold_count,
  input wire addr_fault
);
  wire mac_go = req_valid && req_class == `DAGM_CL_MAC;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // first edge after release may still show the reset value
  chk_bus_okay: assert property (!hresp && (!$past(hresetn) || hreadyout))
    else $error("bus answer not okay or waiting");
  chk_valid_pulse: assert property (req_valid |=> out_valid)
    else $error("request not answered in one cycle");
  chk_branch_lit: assert property (
    req_valid && req_class == `DAGM_CL_BRA |=> branch_disp == $past(literal))
    else $error("branch literal wrong");
  chk_hold_lit: assert property (
    req_valid && req_class == `DAGM_CL_HOLD
      |=> hold_count == $past(literal[13:0]))
    else $error("hold literal wrong");
  chk_mac_amount: assert property (
    mac_go && mac_x_mode == `DAGM_MAC_POST && mac_x_amt == 2'h0
      |=> addr_fault)
    else $error("zero post-modify not flagged");
  chk_mac_index: assert property (
    mac_go && mac_x_mode == `DAGM_MAC_IDX && !mac_x_reg |=> addr_fault)
    else $error("indexing through first X pointer not flagged");
  chk_lit_fault: assert property (req_valid && lit_sel == 2'h3 |=> addr_fault)
    else $error("bad literal select not flagged");
  chk_mac_xroute: assert property (
    mac_go && mac_x_mode != `DAGM_MAC_NONE |=> x_rd_en && !x_wr_en)
    else $error("mac X fetch not on read generator");
  chk_mac_yroute: assert property (
    mac_go && mac_y_mode != `DAGM_MAC_NONE |=> y_en)
    else $error("mac Y fetch missing");
  chk_mac_xaddr: assert property (
    mac_go && mac_x_mode == `DAGM_MAC_IND
      |=> x_rd_addr == $past(w_file[{3'h4, mac_x_reg}*16 +: 16]))
    else $error("mac X indirect address wrong");
  chk_write_class: assert property (
    req_valid && req_class != `DAGM_CL_MOVE |=> !x_wr_en)
    else $error("X write outside move class");
endmodule // dagm_top_chk

bind dagm_top dagm_top_chk i_dagm_top_chk (.hclk, .hresetn, .hreadyout,
  .hresp, .req_valid, .req_class, .lit_sel, .literal, .mac_x_mode,
  .mac_x_reg, .mac_x_amt, .mac_y_mode, .w_file, .out_valid, .x_rd_en,
  .x_rd_addr, .x_wr_en, .y_en, .branch_disp, .hold_count, .addr_fault);

// file: test/dagm_top_tb.sv
`timescale 1ns/1ps
`include "dagm_defines.vh"
`define CHK(n, e, g) check(n, 32'(e), 32'(g));

module dagm_top_tb;
  logic hclk, hresetn, hsel, hwrite, req_valid, byte_op, set_en;
  logic mac_x_reg, mac_x_dec, mac_y_reg, mac_y_dec;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans, req_class, lit_sel, mac_x_mode, mac_x_amt;
  logic [1:0] mac_y_mode, mac_y_amt;
  logic [2:0] hsize, src_mode, dst_mode;
  logic [3:0] src_reg, dst_reg, offset_register_field, set_idx;
  logic [15:0] literal, set_data;
  wire [255:0] w_file;
  wire [31:0] hrdata;
  wire hreadyout, hresp, out_valid, x_rd_en, x_wr_en, y_en, wb0_en, wb1_en;
  wire addr_fault;
  wire [15:0] x_rd_addr, x_wr_addr, y_addr, wb0_data, wb1_data;
  wire [15:0] operand_literal, branch_disp;
  wire [13:0] hold_count;
  wire [3:0] wb0_idx, wb1_idx;
  wire hready = hreadyout;
  int err_total, n_checks, cyc;
  // register readback after writing all ones; last two are status, hole
  logic [31:0] rx [8] = '{32'hCFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
    32'hFFFF, 32'h0, 32'h0};
  // X buffer sweep: control, mode, pointer, address, new pointer
  logic [15:0] tc [6] = '{16'h8FF2, 16'h8FF2, 16'h8FF2, 16'h8FF2,
    16'h8FFF, 16'h0FF2};
  logic [2:0] tm [6] = '{3'h4, 3'h2, 3'h6, 3'h5, 3'h4, 3'h4};
  logic [15:0] tp [6] = '{16'h100E, 16'h100E, 16'h1000, 16'h1000,
    16'h100E, 16'h100E};
  logic [15:0] ta [6] = '{16'h1000, 16'h100E, 16'h1002, 16'h100E,
    16'h1010, 16'h1010};
  logic [15:0] tw [6] = '{16'h1000, 16'h1000, 16'h0, 16'h100E,
    16'h1010, 16'h1010};

  dagm_top i_dagm_top (.*);
  dagm_rf_model i_dagm_rf_model (.hclk, .hresetn, .set_en, .set_idx,
    .set_data, .wb0_en, .wb0_idx, .wb0_data, .wb1_en, .wb1_idx, .wb1_data,
    .w_file);

  // free-running clock, 20 ns period
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      complete_run;
    end
  end

  task automatic check(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // single transfer; address phase held until ready, data taken at 2nd edge
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic setw(input logic [3:0] i, input logic [15:0] v);
    @(posedge hclk);
    set_en <= 1'b1;
    set_idx <= i;
    set_data <= v;
    @(posedge hclk);
    set_en <= 1'b0;
  endtask

  // one-cycle request; results settle one edge later
  task automatic go(input logic [1:0] c, input logic [2:0] sm,
    input logic [3:0] sr, input logic [2:0] dm, input logic [3:0] dr,
    input logic [1:0] ls, input logic [15:0] lt);
    @(posedge hclk);
    req_class <= c;
    src_mode <= sm;
    src_reg <= sr;
    dst_mode <= dm;
    dst_reg <= dr;
    lit_sel <= ls;
    literal <= lt;
    req_valid <= 1'b1;
    @(posedge hclk);
    req_valid <= 1'b0;
    #1;
  endtask

  task automatic mac(input logic [1:0] xm, input logic xr,
    input logic [1:0] xa, input logic [1:0] ym, input logic yr);
    @(posedge hclk);
    mac_x_mode <= xm;
    mac_x_reg <= xr;
    mac_x_amt <= xa;
    mac_y_mode <= ym;
    mac_y_reg <= yr;
    go(`DAGM_CL_MAC, 3'h0, 4'h0, 3'h0, 4'h0, 2'h0, 16'h0);
  endtask

  initial
  begin
    {hsel, hwrite, req_valid, byte_op, set_en, mac_x_reg, mac_y_reg} = '0;
    {haddr, hwdata, htrans, req_class, lit_sel, mac_x_mode} = '0;
    {mac_x_amt, mac_y_mode, src_mode, dst_mode, src_reg, dst_reg} = '0;
    {set_idx, literal, set_data} = '0;
    {mac_x_dec, mac_y_dec, mac_y_amt} = 4'h2;
    hsize = 3'h2;
    offset_register_field = 4'h3;
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, 32'(i * 4), 32'h0);
      `CHK("reset value", 32'h0, rd)
      bus(1'b1, 32'(i * 4), 32'hFFFFFFFF);
      bus(1'b0, 32'(i * 4), 32'h0);
      `CHK("register access", rx[i], rd)
    end
    $display("test registers done");
    bus(1'b1, `DAGM_OFS_XSRT, 32'h1000);
    bus(1'b1, `DAGM_OFS_XEND, 32'h100F);
    bus(1'b1, `DAGM_OFS_BREV, 32'h0);
    setw(4'h3, 16'h0012);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, `DAGM_OFS_CTRL, 32'(tc[i]));
      setw(4'h2, tp[i]);
      go(`DAGM_CL_MOVE, tm[i], 4'h2, `DAGM_MD_DIR, 4'h0, 2'h0, 16'h0);
      `CHK("x read addr", ta[i], x_rd_addr)
      `CHK("x read wb", tm[i] != `DAGM_MD_ROFS, wb0_en)
      if (tm[i] != `DAGM_MD_ROFS)
        `CHK("x read ptr", tw[i], wb0_data)
    end
    bus(1'b1, `DAGM_OFS_XEND, 32'h100D);
    bus(1'b1, `DAGM_OFS_CTRL, 32'h8FF2);
    setw(4'h2, 16'h0FF0);
    go(`DAGM_CL_MOVE, `DAGM_MD_PREI, 4'h2, `DAGM_MD_DIR, 4'h0, 2'h0, 16'h0);
    `CHK("one-way buffer", 16'h0FF2, x_rd_addr)
    bus(1'b1, `DAGM_OFS_XEND, 32'h100F);
    $display("test x modulo done");
    bus(1'b1, `DAGM_OFS_CTRL, 32'h0FFF);
    setw(4'h4, 16'h0100);
    setw(4'h5, 16'h0200);
    go(`DAGM_CL_MOVE, `DAGM_MD_ROFS, 4'h4, `DAGM_MD_ROFS, 4'h5, 2'h1,
      16'h12AB);
    `CHK("shared src offset", 16'h0112, x_rd_addr)
    `CHK("shared dst offset", 16'h0212, x_wr_addr)
    `CHK("lit8", 16'h00AB, operand_literal)
    go(`DAGM_CL_MOVE, `DAGM_MD_LOFS, 4'h4, `DAGM_MD_IND, 4'h5, 2'h2,
      16'h0010);
    `CHK("literal offset", 16'h0110, x_rd_addr)
    `CHK("lit16", 16'h0010, operand_literal)
    `CHK("dst indirect", 16'h0200, x_wr_addr)
    @(posedge hclk) byte_op <= 1'b1;
    go(`DAGM_CL_MOVE, `DAGM_MD_POSTI, 4'h4, `DAGM_MD_DIR, 4'h0, 2'h0, 16'h0);
    `CHK("byte step", 16'h0101, wb0_data)
    @(posedge hclk) byte_op <= 1'b0;
    go(`DAGM_CL_MOVE, `DAGM_MD_DIR, 4'h0, `DAGM_MD_DIR, 4'h0, 2'h3, 16'h0);
    `CHK("bad literal", 1'b1, addr_fault)
    go(`DAGM_CL_BRA, 3'h0, 4'h0, 3'h0, 4'h0, 2'h0, 16'h8001);
    `CHK("branch", 16'h8001, branch_disp)
    go(`DAGM_CL_HOLD, 3'h0, 4'h0, 3'h0, 4'h0, 2'h0, 16'hFFFF);
    `CHK("hold", 14'h3FFF, hold_count)
    $display("test move done");
    bus(1'b1, `DAGM_OFS_CTRL, 32'h4FAF);
    bus(1'b1, `DAGM_OFS_YSRT, 32'h2000);
    bus(1'b1, `DAGM_OFS_YEND, 32'h2007);
    setw(4'h8, 16'h0300);
    setw(4'h9, 16'h0400);
    setw(4'hA, 16'h2006);
    mac(`DAGM_MAC_IDX, 1'b1, 2'h1, `DAGM_MAC_POST, 1'b0);
    `CHK("mac x index", 16'h0412, x_rd_addr)
    `CHK("mac x index wb", 1'b0, wb0_en)
    `CHK("mac y addr", 16'h2006, y_addr)
    `CHK("mac y idx", 4'hA, wb1_idx)
    `CHK("mac y wrap", 16'h2002, wb1_data)
    `CHK("mac fault", 1'b0, addr_fault)
    setw(4'hA, 16'h2005);
    mac(`DAGM_MAC_POST, 1'b0, 2'h3, `DAGM_MAC_IND, 1'b0);
    `CHK("mac x post6", 16'h0306, wb0_data)
    `CHK("mac x idx", 4'h8, wb0_idx)
    `CHK("y word", 16'h2004, y_addr)
    mac(`DAGM_MAC_IDX, 1'b0, 2'h1, `DAGM_MAC_NONE, 1'b0);
    `CHK("no y fetch", 1'b0, y_en)
    mac(`DAGM_MAC_POST, 1'b1, 2'h0, `DAGM_MAC_NONE, 1'b0);
    mac(`DAGM_MAC_IND, 1'b1, 2'h1, `DAGM_MAC_NONE, 1'b0);
    `CHK("mac x indirect", 16'h0400, x_rd_addr)
    $display("test mac done");
    bus(1'b1, `DAGM_OFS_CTRL, 32'h85F5);
    bus(1'b1, `DAGM_OFS_BREV, 32'h8008);
    setw(4'h5, 16'h100E);
    go(`DAGM_CL_MOVE, `DAGM_MD_PREI, 4'h5, `DAGM_MD_POSTI, 4'h5, 2'h0, 16'h0);
    `CHK("read keeps modulo", 16'h1000, x_rd_addr)
    `CHK("bitrev ea", 16'h100E, x_wr_addr)
    `CHK("bitrev ptr", 16'h101E, wb1_data)
    setw(4'h5, 16'h100E);
    go(`DAGM_CL_MOVE, `DAGM_MD_DIR, 4'h0, `DAGM_MD_POSTD, 4'h5, 2'h0, 16'h0);
    `CHK("no bitrev on dec", 16'h100C, wb1_data)
    $display("test bit reverse done");
    complete_run;
  end
endmodule // dagm_top_tb
